// File: rtl/uad_decoder.sv
// User mode address decoder top
// Function
// - Decode 14-bit address over 16 Kbyte space
// - One region selected per access, stack with RAM
// - Low 32 bytes are register slots
// - RAM selected 0x0050 to 0x010F
// - Stack window 0x00C0 to 0x00FF
// - Data EEPROM 128 bytes from 0x0140
// - EEPROM programming register at slot 0x1C
// - Program EEPROM 0x1FC0 to 0x3EFF
// - Page-zero EEPROM 0x0020 to 0x004F
// - User vectors 0x3FF0 to 0x3FFF
// - Program EEPROM writes only in bootloader
// - Port data registers at slots 0-3
// - Port direction registers at slots 4-7
// - Timer and alternate counter at 0x18-0x1B
// - Capture and compare at 0x14-0x17
// - Converter registers at 0x1D, 0x1E
// - Timer control, status at 0x12, 0x13
// - Bus clock is oscillator over two
// - Serial port registers at 0x0A-0x0C
`timescale 1ns/10ps
`include "uad_consts.svh"
module uad_decoder import uad_pkg::*; #(
   parameter int AW = `UAD_AW,
   parameter int DW = `UAD_DW
) (
   input  wire logic            clk,
   input  wire logic            resetn,
   input  wire logic            boot_mode,
   input  wire uad_req_t        req,
   output logic                 bus_phase_clock,
   output uad_rsel_t            rsel,
   output logic [31:0]          io_sel,
   output logic                 rd_en,
   output logic                 wr_en,
   output logic [AW-1:0]        addr_out,
   output logic [DW-1:0]        wdata_out,
   output logic                 undef_rd
);
   ////////////////////////////////////////////////////////////
   // Reset release
   logic rst_s1;
   logic rst_n;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_s1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n  <= rst_s1;
      end
   end

   ////////////////////////////////////////////////////////////
   // Boot mode strap input synchroniser
   logic boot_s1;
   logic boot_s2;
   logic boot_s3;
   logic boot_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         boot_s1 <= 1'b0;
         boot_s2 <= 1'b0;
         boot_s3 <= 1'b0;
         boot_q  <= 1'b0;
      end else begin
         boot_s1 <= boot_mode;
         boot_s2 <= boot_s1;
         boot_s3 <= boot_s2;
         if (boot_s2 == boot_s3) begin
            boot_q <= boot_s3;
         end
      end
   end

   ////////////////////////////////////////////////////////////
   // Bus phase clock: clk divided by two
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_phase_clock <= 1'b0;
      end else begin
         bus_phase_clock <= ~bus_phase_clock;
      end
   end

   ////////////////////////////////////////////////////////////
   // Region decode
   uad_region_t region;
   logic        in_stack;

   uad_region_decode u_region (
      .addr     (req.addr),
      .region   (region),
      .in_stack (in_stack)
   );

   ////////////////////////////////////////////////////////////
   // Slot table of the register space
   function automatic logic slot_known(input logic [4:0] s);
      logic k;
      k = 1'b0;
      unique case (s)
         `UAD_SLOT_PDA: k = 1'b1;
         5'h01:         k = 1'b1;
         5'h02:         k = 1'b1;
         5'h03:         k = 1'b1;

         `UAD_SLOT_DDA: k = 1'b1;
         5'h05:         k = 1'b1;
         5'h06:         k = 1'b1;
         5'h07:         k = 1'b1;

         5'h08:         k = 1'b0;
         5'h09:         k = 1'b0;

         `UAD_SLOT_SCR: k = 1'b1;
         `UAD_SLOT_SSR: k = 1'b1;
         `UAD_SLOT_SDR: k = 1'b1;

         5'h0D:         k = 1'b0;
         5'h0E:         k = 1'b0;
         5'h0F:         k = 1'b0;
         5'h10:         k = 1'b0;
         5'h11:         k = 1'b0;

         `UAD_SLOT_TCR: k = 1'b1;
         `UAD_SLOT_TSR: k = 1'b1;

         `UAD_SLOT_ICH: k = 1'b1;
         `UAD_SLOT_ICL: k = 1'b1;
         `UAD_SLOT_OCH: k = 1'b1;
         `UAD_SLOT_OCL: k = 1'b1;

         `UAD_SLOT_TMH: k = 1'b1;
         `UAD_SLOT_TML: k = 1'b1;
         `UAD_SLOT_ACH: k = 1'b1;
         `UAD_SLOT_ACL: k = 1'b1;

         `UAD_SLOT_EEP: k = 1'b1;
         `UAD_SLOT_ADR: k = 1'b1;
         `UAD_SLOT_ADC: k = 1'b1;

         5'h1F:         k = 1'b0;
      endcase
      return k;
   endfunction : slot_known

   function automatic logic [31:0] slot_onehot(input logic [4:0] s);
      return 32'h00000001 << s;
   endfunction : slot_onehot

   function automatic logic prog_region(input uad_region_t r);
      return (r == UAD_RGN_PE) || (r == UAD_RGN_PZ) || (r == UAD_RGN_UV);
   endfunction : prog_region

   ////////////////////////////////////////////////////////////
   // Next select values
   uad_rsel_t   next_rsel;
   logic [31:0] next_io_sel;
   logic        next_rd;
   logic        next_wr;
   logic        next_undef;
   logic [4:0]  slot;
   logic        prog_blk;
   logic        slot_ok;

   assign slot    = req.addr[4:0];
   assign slot_ok = slot_known(slot);
   // Program EEPROM regions are write protected outside bootloader
   assign prog_blk = req.wr && !boot_q && prog_region(region);

   ////////////////////////////////////////////////////////////
   // Next region select
   always_comb begin
      next_rsel = '0;
      if (req.valid) begin
         unique case (region)
            UAD_RGN_IO:   next_rsel.io = 1'b1;
            UAD_RGN_PZ:   next_rsel.pz = 1'b1;
            UAD_RGN_RAM: begin
               next_rsel.ram   = 1'b1;
               next_rsel.stack = in_stack;
            end
            UAD_RGN_EE:   next_rsel.ee = 1'b1;
            UAD_RGN_PE:   next_rsel.pe = 1'b1;
            UAD_RGN_UV:   next_rsel.uv = 1'b1;
            UAD_RGN_NONE: next_rsel    = '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////
   // Next register slot select
   always_comb begin
      next_io_sel = 32'h00000000;
      if (req.valid && region == UAD_RGN_IO && slot_ok) begin
         next_io_sel = slot_onehot(slot);
      end
   end

   ////////////////////////////////////////////////////////////
   // Next read strobe
   always_comb begin
      next_rd = req.valid && !req.wr;
   end

   ////////////////////////////////////////////////////////////
   // Next write strobe
   always_comb begin
      next_wr = 1'b0;
      if (req.valid && req.wr) begin
         unique case (region)
            UAD_RGN_IO:                         next_wr = slot_ok;
            UAD_RGN_RAM, UAD_RGN_EE:            next_wr = 1'b1;
            UAD_RGN_PZ, UAD_RGN_PE, UAD_RGN_UV: next_wr = !prog_blk;
            UAD_RGN_NONE:                       next_wr = 1'b0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////
   // Next undefined read flag
   always_comb begin
      next_undef = 1'b0;
      if (req.valid && !req.wr) begin
         next_undef = (region == UAD_RGN_NONE) || (region == UAD_RGN_IO && !slot_ok);
      end
   end

   ////////////////////////////////////////////////////////////
   // Registered region select
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rsel <= '0;
      end else begin
         rsel <= next_rsel;
      end
   end

   ////////////////////////////////////////////////////////////
   // Registered register slot select
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         io_sel <= 32'h00000000;
      end else begin
         io_sel <= next_io_sel;
      end
   end

   ////////////////////////////////////////////////////////////
   // Registered read strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_en <= 1'b0;
      end else begin
         rd_en <= next_rd;
      end
   end

   ////////////////////////////////////////////////////////////
   // Registered write strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_en <= 1'b0;
      end else begin
         wr_en <= next_wr;
      end
   end

   ////////////////////////////////////////////////////////////
   // Registered undefined read flag
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         undef_rd <= 1'b0;
      end else begin
         undef_rd <= next_undef;
      end
   end

   ////////////////////////////////////////////////////////////
   // Delayed bus address
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_out <= '0;
      end else begin
         addr_out <= req.addr[AW-1:0];
      end
   end

   ////////////////////////////////////////////////////////////
   // Delayed write data
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wdata_out <= '0;
      end else begin
         wdata_out <= req.wdata[DW-1:0];
      end
   end
endmodule : uad_decoder

// File: rtl/uad_consts.svh
// Address map constants for the user mode address decoder
`ifndef UAD_CONSTS_SVH
`define UAD_CONSTS_SVH
`define UAD_AW          14
`define UAD_DW          8
`define UAD_IO_LO       14'h0000
`define UAD_IO_HI       14'h001F
`define UAD_PZ_LO       14'h0020
`define UAD_PZ_HI       14'h004F
`define UAD_RAM_LO      14'h0050
`define UAD_RAM_HI      14'h010F
`define UAD_STK_LO      14'h00C0
`define UAD_STK_HI      14'h00FF
`define UAD_EE_LO       14'h0140
`define UAD_EE_HI       14'h01BF
`define UAD_PE_LO       14'h1FC0
`define UAD_PE_HI       14'h3EFF
`define UAD_UV_LO       14'h3FF0
`define UAD_UV_HI       14'h3FFF
`define UAD_SLOT_PDA    5'h00
`define UAD_SLOT_DDA    5'h04
`define UAD_SLOT_SCR    5'h0A
`define UAD_SLOT_SSR    5'h0B
`define UAD_SLOT_SDR    5'h0C
`define UAD_SLOT_TCR    5'h12
`define UAD_SLOT_TSR    5'h13
`define UAD_SLOT_ICH    5'h14
`define UAD_SLOT_ICL    5'h15
`define UAD_SLOT_OCH    5'h16
`define UAD_SLOT_OCL    5'h17
`define UAD_SLOT_TMH    5'h18
`define UAD_SLOT_TML    5'h19
`define UAD_SLOT_ACH    5'h1A
`define UAD_SLOT_ACL    5'h1B
`define UAD_SLOT_EEP    5'h1C
`define UAD_SLOT_ADR    5'h1D
`define UAD_SLOT_ADC    5'h1E
`define UAD_UNDEF_RD    8'h00
`endif

// File: rtl/uad_pkg.sv
// Types shared by the user mode address decoder
package uad_pkg;
   typedef enum logic [2:0] {
      UAD_RGN_NONE,
      UAD_RGN_IO,
      UAD_RGN_PZ,
      UAD_RGN_RAM,
      UAD_RGN_EE,
      UAD_RGN_PE,
      UAD_RGN_UV
   } uad_region_t;

   typedef struct packed {
      logic        valid;
      logic        wr;
      logic [13:0] addr;
      logic [7:0]  wdata;
   } uad_req_t;

   typedef struct packed {
      logic        io;
      logic        pz;
      logic        ram;
      logic        stack;
      logic        ee;
      logic        pe;
      logic        uv;
   } uad_rsel_t;
endpackage : uad_pkg

// File: rtl/uad_region_decode.sv
// Combinational region decode of a bus address
`timescale 1ns/10ps
`include "uad_consts.svh"
module uad_region_decode import uad_pkg::*; (
   input  wire logic [13:0] addr,
   output uad_region_t      region,
   output logic             in_stack
);
   always_comb begin
      region = UAD_RGN_NONE;
      if (addr <= `UAD_IO_HI) begin
         region = UAD_RGN_IO;
      end else if (addr >= `UAD_PZ_LO && addr <= `UAD_PZ_HI) begin
         region = UAD_RGN_PZ;
      end else if (addr >= `UAD_RAM_LO && addr <= `UAD_RAM_HI) begin
         region = UAD_RGN_RAM;
      end else if (addr >= `UAD_EE_LO && addr <= `UAD_EE_HI) begin
         region = UAD_RGN_EE;
      end else if (addr >= `UAD_PE_LO && addr <= `UAD_PE_HI) begin
         region = UAD_RGN_PE;
      end else if (addr >= `UAD_UV_LO) begin
         region = UAD_RGN_UV;
      end
   end

   assign in_stack = (addr >= `UAD_STK_LO) && (addr <= `UAD_STK_HI);
endmodule : uad_region_decode

// File: testbench/uad_decoder_sva.sv
// Assertion checker for the user mode address decoder
`timescale 1ns/10ps
module uad_decoder_sva import uad_pkg::*; #(
   parameter int AW = 14
) (
   input wire logic          clk,
   input wire logic          resetn,
   input wire logic          boot_mode,
   input wire uad_req_t      req,
   input wire logic          bus_phase_clock,
   input wire uad_rsel_t     rsel,
   input wire logic [31:0]   io_sel,
   input wire logic          rd_en,
   input wire logic          wr_en,
   input wire logic [AW-1:0] addr_out
);
   logic [2:0] up;
   logic       emp;
   assign emp = req.addr inside {[14'h0008:14'h0009], [14'h000D:14'h0011], 14'h001F};
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) up <= 3'h0;
      else if (up != 3'h7) up <= up + 3'h1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   chk_phase_toggle: assert property (up == 3'h7 |-> bus_phase_clock != $past(bus_phase_clock))
      else $error("bus phase clock stalled");
   chk_ram_window: assert property (req.valid |=> rsel.ram == ($past(req.addr) inside {[14'h0050:14'h010F]}))
      else $error("ram select wrong");
   chk_stack_in_ram: assert property (rsel.stack |-> rsel.ram && addr_out inside {[14'h00C0:14'h00FF]})
      else $error("stack select wrong");
   chk_ee_window: assert property (req.valid |=> rsel.ee == ($past(req.addr) inside {[14'h0140:14'h01BF]}))
      else $error("data eeprom select wrong");
   chk_pe_locked: assert property ((!boot_mode)[*6] ##0 (req.valid && req.wr && req.addr >= 14'h1FC0
      && req.addr <= 14'h3EFF) |=> !wr_en)
      else $error("program eeprom write in user mode");
   chk_slot_onehot: assert property (req.valid && req.addr < 14'h0020 && !emp
      |=> io_sel == 32'h1 << $past(req.addr[4:0]))
      else $error("slot select wrong");
   chk_empty_slot: assert property (req.valid && req.addr < 14'h0020 && emp |=> io_sel == 32'h0 && !wr_en)
      else $error("empty slot selected");
   chk_one_select: assert property ($onehot0(io_sel) && $onehot0({rsel.io, rsel.pz, rsel.ram, rsel.ee, rsel.pe,
      rsel.uv}))
      else $error("several selects at once");
   chk_addr_pass: assert property (req.valid |=> addr_out == $past(req.addr) && rd_en != $past(req.wr))
      else $error("address or read strobe wrong");
endmodule : uad_decoder_sva
bind uad_decoder uad_decoder_sva #(.AW(AW)) i_chk (.clk, .resetn, .boot_mode, .req, .bus_phase_clock, .rsel,
   .io_sel, .rd_en, .wr_en, .addr_out);

// File: testbench/uad_cpu_model.sv
// CPU side request model driving the decoder bus
`timescale 1ns/10ps
module uad_cpu_model import uad_pkg::*; (
   output uad_req_t req
);
   initial req = '0;
   task put(input bit v, input bit w, input logic [13:0] a, input logic [7:0] d);
      if (v) req <= {v, w, a, d};
      else req <= {2'h0, ~req.addr, ~req.wdata};
   endtask : put
endmodule : uad_cpu_model

// File: testbench/testbench.sv
// Self-checking bench for the user mode address decoder
`timescale 1ns/10ps
module testbench;
   logic                clk = 1'b0;
   logic                resetn = 1'b0;
   logic                boot_mode = 1'b0;
   uad_pkg::uad_req_t   req;
   uad_pkg::uad_rsel_t  rsel;
   logic                bus_phase_clock, rd_en, wr_en, undef_rd;
   logic [31:0]         io_sel;
   logic [13:0]         addr_out;
   logic [7:0]          wdata_out;
   int                  err_total = 0, checks = 0, seed = 32'h493099F4;
   int                  pv, pa, pw, pd, pb, cyc = 0;
   int lst [40] = '{0, 3, 4, 7, 8, 9, 10, 12, 13, 17, 18, 19, 20, 23, 24, 27, 28, 29, 30, 31, 32, 79, 80, 191, 192,
      255, 256, 271, 272, 319, 320, 447, 448, 8127, 8128, 16127, 16128, 16367, 16368, 16383};
   always #4 clk = ~clk;
   always @(posedge clk) begin
      if (resetn) cyc <= cyc + 1;
   end
   uad_cpu_model i_cpu (.req(req));
   uad_decoder #(.AW(14), .DW(8)) i_dut (.clk(clk), .resetn(resetn), .boot_mode(boot_mode), .req(req),
      .bus_phase_clock(bus_phase_clock), .rsel(rsel), .io_sel(io_sel), .rd_en(rd_en), .wr_en(wr_en),
      .addr_out(addr_out), .wdata_out(wdata_out), .undef_rd(undef_rd));
   ////////////////////////////////////////////////////////////////
   task end_sim;
      if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   task cmp(input bit ok);
      checks++;
      if (!ok) begin
         err_total++;
         $display("CHECK FAILED at %0t: decode mismatch for address %h write %0d", $time, pa, pw);
      end
   endtask : cmp
   task check_prev;
      bit io, pz, ram, st, ee, pe, uv, emp, mp;
      io = pa < 32;
      pz = pa >= 32 && pa < 80;
      ram = pa >= 80 && pa < 272;
      st = pa >= 192 && pa < 256;
      ee = pa >= 320 && pa < 448;
      pe = pa >= 8128 && pa < 16128;
      uv = pa >= 16368;
      emp = io && (pa == 8 || pa == 9 || (pa >= 13 && pa <= 17) || pa == 31);
      mp = io || pz || ram || ee || pe || uv;
      cmp({rsel.pz, rsel.ram, rsel.stack, rsel.ee, rsel.pe, rsel.uv} === {pz, ram, st, ee, pe, uv});
      cmp(rsel.io === io);
      cmp(io_sel === ((io && !emp) ? 32'h1 << pa : 32'h0));
      cmp(wr_en === (pw && mp && !emp && !((pz || pe || uv) && !pb)));
      cmp(undef_rd === (!pw && (!mp || emp)));
      cmp(rd_en === !pw && addr_out === pa[13:0] && wdata_out === pd[7:0]);
   endtask : check_prev
   task op(input int v, input int a, input int w, input int d);
      @(posedge clk);
      i_cpu.put(v[0], w[0], a[13:0], d[7:0]);
      @(negedge clk);
      cmp(bus_phase_clock === (cyc > 2 && cyc[0]));
      if (pv != 0) check_prev;
      else cmp(rd_en === 1'b0 && wr_en === 1'b0);
      pv = v;
      pa = a;
      pw = w;
      pd = d;
      pb = boot_mode;
   endtask : op
   initial begin
      pv = 0;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
      for (int b = 0; b < 2; b++) begin
         @(posedge clk);
         boot_mode <= b[0];
         repeat (8) @(posedge clk);
         foreach (lst[i]) for (int w = 0; w < 2; w++) op(1, lst[i], w, $random(seed));
         op(0, 0, 0, 0);
      end
      repeat (300) op($random(seed) & 1, $random(seed) & 16'h3FFF, $random(seed) & 1, $random(seed));
      op(0, 0, 0, 0);
      end_sim;
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      end_sim;
   end
endmodule : testbench
